// File: hw/sad_bitband.sv
`timescale 1ns/1ps
`default_nettype none

module sad_bitband
  import sad_pkg::*;
(
  input  wire logic [31:0] addr,
  output logic             alias_hit,
  output logic [31:0]      phys_addr,
  output logic [4:0]       bit_idx
);

  // Each alias word stands for one bit: bits 24:7 pick the word, 6:2 the bit.
  assign alias_hit = (addr[31:25] == BB_SRAM_ALIAS_TAG)
                   | (addr[31:25] == BB_PERIPH_ALIAS_TAG);
  assign phys_addr = {addr[31:28], 8'h00, addr[24:7], 2'b00};
  assign bit_idx   = addr[6:2];

endmodule : sad_bitband

`default_nettype wire

// File: hw/sad_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Flash window 0x0000_0000-0x0000_FFFF selects flash; unpopulated flash faults.
// - SRAM window 0x2000_0000-0x2000_1FFF selects SRAM; unpopulated SRAM faults.
// - Alias from 0x2200_0000 becomes one-bit access on SRAM area word.
// - Alias 0x4200_0000-0x43FF_FFFF becomes one-bit access on peripheral word.
// - Unassigned or reserved addresses, including peripheral gaps, answer bus fault.
// - 0xE000_E000-0xE000_EFFF selects the vectored interrupt controller.
// - 0xE004_0000-0xE004_0FFF selects trace port unit; above to 0xE00F_FFFF faults.
// - Three debug windows at 0xE000_0000/1000/2000; rest to 0xE000_DFFF reserved.
// - 0xE010_0000 through 0xFFFF_FFFF is vendor space and always faults.
// - Selected target receives address bits below its window base as offset.
module sad_decoder
  import sad_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire sad_req_s              req,
  output logic                       tgt_valid,
  output logic                       tgt_write,
  output logic [NUM_TGT-1:0]         tgt_sel,
  output sad_tgt_e                   tgt_id,
  output logic [OFS_W-1:0]           tgt_offset,
  output logic [31:0]                tgt_wdata,
  output logic                       tgt_bit_en,
  output logic [31:0]                tgt_bit_mask,
  output logic                       rsp_fault,
  output sad_fault_e                 rsp_cause
);

  sad_state_s         st;
  sad_state_s         next_st;
  logic               alias_hit;
  logic [31:0]        alias_phys;
  logic [4:0]         alias_bit;
  logic [31:0]        eff_addr;
  logic [NUM_TGT-1:0] hits;
  logic [NUM_TGT-1:0] one_hit;

  // Alias translation of the incoming address.
  sad_bitband u_bitband (
    .addr      (req.addr),
    .alias_hit (alias_hit),
    .phys_addr (alias_phys),
    .bit_idx   (alias_bit)
  );

  // Alias accesses are decoded against the word they stand for.
  assign eff_addr = alias_hit ? alias_phys : req.addr;

  // One window comparator per target; the gaps between windows hit nothing.
  for (genvar g = 0; g < NUM_TGT; g++) begin : g_win
    sad_window_match #(
      .BASE (WIN_BASE[g]),
      .MASK (WIN_MASK[g])
    ) u_match (
      .addr (eff_addr),
      .hit  (hits[g])
    );
  end

  // Keep only the lowest hit so a table slip can never raise two selects.
  assign one_hit = hits & (~hits + {{(NUM_TGT-1){1'b0}}, 1'b1});

  // Decode the request into the next registered result.
  always_comb begin
    next_st          = '0;
    next_st.valid    = req.valid & (|one_hit);
    next_st.write    = req.write;
    next_st.wdata    = req.wdata;
    next_st.fault    = req.valid & ~(|one_hit);
    next_st.cause    = FLT_NONE;
    next_st.tgt      = TGT_FLASH;
    next_st.offset   = '0;
    if (req.valid) begin
      next_st.sel = one_hit;
      for (int i = 0; i < NUM_TGT; i++) begin
        if (one_hit[i]) begin
          next_st.tgt    = sad_tgt_e'(i[4:0]);
          next_st.offset = OFS_W'(eff_addr & WIN_MASK[i]);
        end
      end
      next_st.bit_en   = alias_hit & (|one_hit);
      next_st.bit_mask = (|one_hit && alias_hit) ? (32'h0000_0001 << alias_bit) : 32'h0000_0000;
      // Classify the fault by the area the address fell in.
      if (~(|one_hit)) begin
        if (alias_hit) begin
          next_st.cause = FLT_ALIAS;
        end else if (eff_addr >= VENDOR_BASE) begin
          next_st.cause = FLT_VENDOR;
        end else if (eff_addr >= PPB_BASE && eff_addr <= PPB_LAST) begin
          next_st.cause = FLT_PRIVATE;
        end else if (eff_addr >= PERIPH_AREA_BASE && eff_addr <= PERIPH_AREA_LAST) begin
          next_st.cause = FLT_PERIPH;
        end else if (eff_addr < WIN_BASE[TGT_FLASH] + 32'h0001_0000
                     || (eff_addr >= SRAM_AREA_BASE && eff_addr <= SRAM_AREA_LAST)) begin
          next_st.cause = FLT_MEMORY;
        end else begin
          next_st.cause = FLT_OTHER;
        end
      end
    end
  end

  // Result register: one cycle from request to select or fault.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the result register.
  assign tgt_valid    = st.valid;
  assign tgt_write    = st.write;
  assign tgt_sel      = st.sel;
  assign tgt_id       = st.tgt;
  assign tgt_offset   = st.offset;
  assign tgt_wdata    = st.wdata;
  assign tgt_bit_en   = st.bit_en;
  assign tgt_bit_mask = st.bit_mask;
  assign rsp_fault    = st.fault;
  assign rsp_cause    = st.cause;

endmodule : sad_decoder

`default_nettype wire

// File: hw/sad_pkg.sv
package sad_pkg;

  // Target identifiers; each one is a bit position in the select vector.
  typedef enum logic [4:0] {
    TGT_FLASH    = 5'h00,
    TGT_SRAM     = 5'h01,
    TGT_WATCHDOG = 5'h02,
    TGT_GPIO_A   = 5'h03,
    TGT_GPIO_B   = 5'h04,
    TGT_GPIO_C   = 5'h05,
    TGT_GPIO_D   = 5'h06,
    TGT_SSI0     = 5'h07,
    TGT_UART0    = 5'h08,
    TGT_UART1    = 5'h09,
    TGT_I2C_MST0 = 5'h0A,
    TGT_I2C_SLV0 = 5'h0B,
    TGT_GPIO_E   = 5'h0C,
    TGT_TIMER0   = 5'h0D,
    TGT_TIMER1   = 5'h0E,
    TGT_TIMER2   = 5'h0F,
    TGT_ADC      = 5'h10,
    TGT_COMP     = 5'h11,
    TGT_FLASHCTL = 5'h12,
    TGT_SYSCTL   = 5'h13,
    TGT_ITU      = 5'h14,
    TGT_DWU      = 5'h15,
    TGT_PBU      = 5'h16,
    TGT_VIC      = 5'h17,
    TGT_TPU      = 5'h18
  } sad_tgt_e;

  localparam int NUM_TGT = 25;
  localparam int OFS_W   = 16;

  // Why an access faulted.
  typedef enum logic [2:0] {
    FLT_NONE      = 3'h0,
    FLT_MEMORY    = 3'h1,
    FLT_ALIAS     = 3'h2,
    FLT_PERIPH    = 3'h3,
    FLT_PRIVATE   = 3'h4,
    FLT_VENDOR    = 3'h5,
    FLT_OTHER     = 3'h6
  } sad_fault_e;

  // Window bases, indexed by target identifier.
  localparam logic [31:0] WIN_BASE [0:NUM_TGT-1] = '{
    32'h0000_0000, 32'h2000_0000, 32'h4000_0000, 32'h4000_4000,
    32'h4000_5000, 32'h4000_6000, 32'h4000_7000, 32'h4000_8000,
    32'h4000_C000, 32'h4000_D000, 32'h4002_0000, 32'h4002_0800,
    32'h4002_4000, 32'h4003_0000, 32'h4003_1000, 32'h4003_2000,
    32'h4003_8000, 32'h4003_C000, 32'h400F_D000, 32'h400F_E000,
    32'hE000_0000, 32'hE000_1000, 32'hE000_2000, 32'hE000_E000,
    32'hE004_0000
  };

  // Offset masks (window size minus one), indexed by target identifier.
  localparam logic [31:0] WIN_MASK [0:NUM_TGT-1] = '{
    32'h0000_FFFF, 32'h0000_1FFF, 32'h0000_0FFF, 32'h0000_0FFF,
    32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF,
    32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_07FF, 32'h0000_07FF,
    32'h0000_3FFF, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF,
    32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_1FFF,
    32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_0FFF,
    32'h0000_0FFF
  };

  // Bit-band alias areas, keyed on address bits 31:25.
  localparam logic [6:0]  BB_SRAM_ALIAS_TAG   = 7'h11;
  localparam logic [6:0]  BB_PERIPH_ALIAS_TAG = 7'h21;

  // Coarse regions used only to classify faults.
  localparam logic [31:0] SRAM_AREA_BASE    = 32'h2000_0000;
  localparam logic [31:0] SRAM_AREA_LAST    = 32'h200F_FFFF;
  localparam logic [31:0] PERIPH_AREA_BASE  = 32'h4000_0000;
  localparam logic [31:0] PERIPH_AREA_LAST  = 32'h400F_FFFF;
  localparam logic [31:0] PPB_BASE          = 32'hE000_0000;
  localparam logic [31:0] PPB_LAST          = 32'hE00F_FFFF;
  localparam logic [31:0] VENDOR_BASE       = 32'hE010_0000;

  // Processor access request.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sad_req_s;

  // Registered decode result, the whole state of the decoder.
  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [NUM_TGT-1:0]   sel;
    sad_tgt_e             tgt;
    logic [OFS_W-1:0]     offset;
    logic [31:0]          wdata;
    logic                 bit_en;
    logic [31:0]          bit_mask;
    logic                 fault;
    sad_fault_e           cause;
  } sad_state_s;

endpackage : sad_pkg

// File: hw/sad_window_match.sv
`timescale 1ns/1ps
`default_nettype none

module sad_window_match #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] MASK = 32'h0000_0FFF
) (
  input  wire logic [31:0] addr,
  output logic             hit
);

  // A window matches when every address bit above its offset equals the base.
  assign hit = ((addr & ~MASK) == BASE);

endmodule : sad_window_match

`default_nettype wire

// File: test/sad_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sad_cpu_model
  import sad_pkg::*;
(
  input  wire logic     core_clk,
  output var  sad_req_s req
);
  // Start idle so the decoder sees no access at time zero.
  initial req = '0;
  // Launch one access at a falling edge; it holds until the next call.
  task automatic access(input logic [31:0] a, input logic wr);
    @(negedge core_clk);
    req <= '{1'b1, wr, a, ~a};
  endtask : access
  // Release the bus; idle lines show inverted stale values.
  task automatic idle();
    @(negedge core_clk);
    req <= '{1'b0, ~req.write, ~req.addr, ~req.wdata};
  endtask : idle
endmodule : sad_cpu_model
`default_nettype wire

// File: test/sad_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sad_properties
  import sad_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst,
  input wire sad_req_s           req,
  input wire logic               tgt_valid,
  input wire logic [NUM_TGT-1:0] tgt_sel,
  input wire sad_tgt_e           tgt_id,
  input wire logic [OFS_W-1:0]   tgt_offset,
  input wire logic               tgt_bit_en,
  input wire logic [31:0]        tgt_bit_mask,
  input wire logic               rsp_fault
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // A taken access, its single answer, and an answer that came through an alias.
  sequence taken_s; req.valid; endsequence
  sequence answer_s; tgt_valid ^ rsp_fault; endsequence
  sequence alias_s; taken_s ##1 tgt_valid && tgt_bit_en; endsequence
  // Each answer is tied to the access that caused it one cycle before.
  one_answer_a: assert property (taken_s |=> answer_s) else $error("no answer");
  idle_quiet_a: assert property (!req.valid |=> !tgt_valid && !rsp_fault)
    else $error("stray answer");
  one_select_a: assert property (tgt_sel == (tgt_valid ? NUM_TGT'(1) << tgt_id : '0))
    else $error("bad select");
  flash_hit_a: assert property (req.valid && req.addr[31:16] == 16'h0000
    |=> tgt_sel[TGT_FLASH]) else $error("flash missed");
  vendor_fault_a: assert property (req.valid && req.addr >= VENDOR_BASE |=> rsp_fault)
    else $error("vendor hit");
  base_match_a: assert property (tgt_valid && !tgt_bit_en
    |-> ($past(req.addr) & ~WIN_MASK[tgt_id]) == WIN_BASE[tgt_id]) else $error("bad base");
  offset_pass_a: assert property (tgt_valid && !tgt_bit_en
    |-> tgt_offset == OFS_W'($past(req.addr) & WIN_MASK[tgt_id])) else $error("bad offset");
  bit_mask_a: assert property (alias_s |-> tgt_bit_mask == 32'h1 << $past(req.addr[6:2]))
    else $error("bad bit mask");
endmodule : sad_properties
bind sad_decoder sad_properties i_sad_properties (.core_clk, .rst, .req, .tgt_valid,
  .tgt_sel, .tgt_id, .tgt_offset, .tgt_bit_en, .tgt_bit_mask, .rsp_fault);
`default_nettype wire

// File: test/system_address_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module system_address_decoder_tb
  import sad_pkg::*;
;
  logic               core_clk = 1'b0;
  logic               rst      = 1'b1;
  sad_req_s           req;
  logic               tgt_valid, tgt_write, tgt_bit_en, rsp_fault;
  logic [NUM_TGT-1:0] tgt_sel;
  sad_tgt_e           tgt_id;
  logic [OFS_W-1:0]   tgt_offset;
  logic [31:0]        tgt_wdata, tgt_bit_mask;
  sad_fault_e         rsp_cause;
  int                 bad_count = 0;
  int                 tests_run = 0;
  localparam logic [34:0] HOLES [8] = '{{32'h2000_2000, FLT_MEMORY},
    {32'h4000_1000, FLT_PERIPH}, {32'h400F_CFFC, FLT_PERIPH}, {32'hE000_3000, FLT_PRIVATE},
    {32'hE000_DFFC, FLT_PRIVATE}, {32'hE004_1000, FLT_PRIVATE}, {32'hE010_0000, FLT_VENDOR},
    {32'hFFFF_FFFC, FLT_VENDOR}};
  sad_cpu_model i_sad_cpu_model (.core_clk, .req);
  sad_decoder i_sad_decoder (.core_clk, .rst, .req, .tgt_valid, .tgt_write, .tgt_sel, .tgt_id,
    .tgt_offset, .tgt_wdata, .tgt_bit_en, .tgt_bit_mask, .rsp_fault, .rsp_cause);
  // Free-running 200 MHz clock.
  always #2.5 core_clk = ~core_clk;
  // Count a comparison and report a mismatch.
  task automatic check(input string what, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Expect a hit on one target with this offset and bit mask.
  task automatic hit(input sad_tgt_e id, input logic [15:0] ofs, input logic [31:0] m);
    check("hit", {tgt_valid, rsp_fault, tgt_id, tgt_offset}, {2'b10, id, ofs});
    check("sel", tgt_sel, NUM_TGT'(1) << id);
    check("bit", {tgt_bit_en, tgt_bit_mask}, {|m, m});
    check("cause", rsp_cause, FLT_NONE);
  endtask : hit
  // Expect a fault of this class with no select.
  task automatic flt(input sad_fault_e c);
    check("flt", {tgt_valid, rsp_fault, rsp_cause, tgt_sel}, {2'b01, c, NUM_TGT'(0)});
  endtask : flt
  // First and last byte of every window, back to back, read then write.
  task automatic test_windows();
    for (int i = 0; i < NUM_TGT; i++) begin
      i_sad_cpu_model.access(WIN_BASE[i], 1'b0);
      i_sad_cpu_model.access(WIN_BASE[i] | WIN_MASK[i], 1'b1);
      hit(sad_tgt_e'(i), 16'h0000, 32'h0);
      check("rd", {tgt_write, tgt_wdata}, {1'b0, ~WIN_BASE[i]});
      i_sad_cpu_model.idle();
      hit(sad_tgt_e'(i), WIN_MASK[i][15:0], 32'h0);
      check("wr", {tgt_write, tgt_wdata}, {1'b1, ~(WIN_BASE[i] | WIN_MASK[i])});
    end
  endtask : test_windows
  // Holes, reserved debug space and vendor space fault on reads and writes.
  task automatic test_faults();
    for (int i = 0; i < 8; i++) begin
      i_sad_cpu_model.access(HOLES[i][34:3], i[0]);
      i_sad_cpu_model.idle();
      flt(sad_fault_e'(HOLES[i][2:0]));
    end
  endtask : test_faults
  // Alias accesses reach one bit of the translated word; unbacked words fault.
  task automatic test_alias();
    i_sad_cpu_model.access(32'h2200_0084, 1'b1);
    i_sad_cpu_model.access(32'h420A_020C, 1'b0);
    hit(TGT_SRAM, 16'h0004, 32'h0000_0002);
    i_sad_cpu_model.access(32'h2203_FFFC, 1'b0);
    hit(TGT_GPIO_B, 16'h0010, 32'h0000_0008);
    i_sad_cpu_model.access(32'h2204_0000, 1'b0);
    hit(TGT_SRAM, 16'h1FFC, 32'h8000_0000);
    i_sad_cpu_model.access(32'h4202_0000, 1'b1);
    flt(FLT_ALIAS);
    i_sad_cpu_model.idle();
    flt(FLT_ALIAS);
  endtask : test_alias
  // A reset over a pending access clears it; decoding resumes afterwards.
  task automatic test_reset();
    i_sad_cpu_model.access(32'h4000_C000, 1'b0);
    rst <= 1'b1;
    i_sad_cpu_model.idle();
    check("rst", {tgt_valid, rsp_fault, tgt_sel, tgt_bit_mask}, '0);
    rst <= 1'b0;
    i_sad_cpu_model.access(32'h4000_C000, 1'b0);
    i_sad_cpu_model.idle();
    hit(TGT_UART0, 16'h0000, 32'h0);
  endtask : test_reset
  // Print the counts and the verdict, then stop.
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // Cut a hang short; the tests need some 120 cycles.
  initial begin
    #10000;
    bad_count++;
    summarize();
  end
  // Hold reset for 20 cycles, then run every scenario.
  initial begin
    repeat (20) @(negedge core_clk);
    rst <= 1'b0;
    test_windows();
    test_faults();
    test_alias();
    test_reset();
    summarize();
  end
endmodule : system_address_decoder_tb
`default_nettype wire
